// >>> design/audio_tuning_supply_mix_regs.sv
// Tuning, supply-volume, control, downmix and clip-gain register bank
// Summary of operation
// RULE_01: BCD: D12 thousands, D11-D8 hundreds digit
// RULE_02: BCD: D7-D4 tens, D3-D0 units; reset zero
// RULE_03: Binary: eleven-bit frequency in D10-D0
// RULE_04: Mode bit D16 picks BCD or binary
// RULE_05: Range codes select 12.04, 18.06, 24.08 dB
// RULE_06: Range code 11 write is ignored
// RULE_07: Range register upper bits hold zero
// RULE_08: Control D1 selects six-channel line-out mode
// RULE_09: Control D2 enables supply-volume control
// RULE_10: Control D3 separates subwoofer from supply volume
// RULE_11: Control D0 and bits above D3 zero
// RULE_12: Coefficients are signed 5.23, unity 0x800000
// RULE_13: First coefficient: in1 both sides; second: in4 left
// RULE_14: Four coefficients route in2 channels to outputs
// RULE_15: In1 coefficient resets to about 1/3.121
// RULE_16: Pre-gain, clip, then post-gain
// RULE_17: Clip gains accept up to 28-bit maximum
// RULE_18: Largest positive clip gain is +24 dB
// RULE_19: Sign bit set gives inverting clip gain
// RULE_20: Clip gains reset to unity
// RULE_21: Word commits only after its last byte
`timescale 1ns/1ns
`default_nettype none
module audio_tuning_supply_mix_regs
    import audio_tuning_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Serial control port, byte level
    input  wire logic             sub_valid,
    input  wire logic [SUB_W-1:0] sub_addr,
    input  wire logic             wr_valid,
    input  wire logic [BYTE_W-1:0] wr_byte,
    input  wire logic             rd_req,
    input  wire logic             stop,
    output logic      [BYTE_W-1:0] rd_byte,
    output logic                  rd_valid,
    // Settings to processing
    output tuning_t               tuning,
    output logic      [1:0]       range_code,
    output logic      [11:0]      range_cdb,
    output logic                  lineout_six_ch,
    output logic                  svc_enable,
    output logic                  sub_separate,
    // Downmix path
    input  wire logic             smp_valid,
    input  wire stereo_t          in1,
    input  wire stereo_t          in2,
    input  wire stereo_t          in4,
    output logic                  mix_valid,
    output stereo_t               mix_out,
    // Clip manager path
    input  wire logic             clip_in_valid,
    input  wire logic signed [SAMPLE_W-1:0] clip_in,
    output logic                  clip_out_valid,
    output logic signed      [SAMPLE_W-1:0] clip_out
);

    localparam int P_W   = SAMPLE_W + COEF_W - FRAC_BITS;
    localparam int SUM_W = P_W + 2;
    localparam int IDX_W = 4;
    localparam logic signed [SUM_W-1:0] SUM_MAX =
        {{(SUM_W-SAMPLE_W+1){1'b0}}, {(SAMPLE_W-1){1'b1}}};
    localparam logic signed [SUM_W-1:0] SUM_MIN = ~SUM_MAX;
    localparam logic [1:0] LAST_BYTE = 2'(WORD_BYTES - 1);

    // Slot index of a subaddress, with holes for unmapped addresses
    function automatic logic [IDX_W:0] slot_of(input logic [SUB_W-1:0] a);
        logic [SUB_W-1:0] d;
        d = a - SUB_TUNED;
        if (a < SUB_TUNED || a > SUB_POST || a == 8'hE1 || a == 8'hE2)
            slot_of = {1'b0, {IDX_W{1'b0}}};
        else
            slot_of = {1'b1, d[IDX_W-1:0]};
    endfunction

    function automatic logic [WORD_W-1:0] slot_reset(input logic [IDX_W-1:0] i);
        case (SUB_TUNED + {4'h0, i})
            SUB_MIX_IN1: slot_reset = RST_MIX_IN1; // RULE_15
            SUB_MIX_IN4: slot_reset = RST_MIX_IN4;
            SUB_IN2L_OR,
            SUB_IN2R_OR,
            SUB_IN2L_OL,
            SUB_IN2R_OL: slot_reset = RST_MIX_IN2;
            SUB_PRE,
            SUB_POST:    slot_reset = RST_UNITY; // RULE_20
            default:     slot_reset = RST_ZERO; // RULE_02
        endcase
    endfunction

    // Stored value after a committed word write
    function automatic logic [WORD_W-1:0] filter_write(
        input logic [IDX_W-1:0]  i,
        input logic [WORD_W-1:0] old_v,
        input logic [WORD_W-1:0] new_v
    );
        case (SUB_TUNED + {4'h0, i})
            SUB_TUNED:   filter_write = new_v & TUNE_KEEP_MASK; // RULE_04
            SUB_RANGE:
            begin
                if (new_v[1:0] == RANGE_IGNORE)
                    filter_write = old_v; // RULE_06
                else
                    filter_write = new_v & RANGE_MASK; // RULE_07
            end
            SUB_GENERAL: filter_write = new_v & GEN_MASK; // RULE_11
            SUB_PRE,
            SUB_POST:    filter_write = new_v & COEF_MASK; // RULE_17
            SUB_MIX_IN1,
            SUB_MIX_IN4,
            SUB_IN2L_OR,
            SUB_IN2R_OR,
            SUB_IN2L_OL,
            SUB_IN2R_OL: filter_write = {{4{new_v[27]}}, new_v[27:0]}; // RULE_12
            default:     filter_write = old_v;
        endcase
    endfunction

    function automatic logic signed [SAMPLE_W-1:0] saturate(input logic signed [SUM_W-1:0] v);
        if (v > SUM_MAX)
            saturate = SUM_MAX[SAMPLE_W-1:0];
        else if (v < SUM_MIN)
            saturate = SUM_MIN[SAMPLE_W-1:0];
        else
            saturate = v[SAMPLE_W-1:0];
    endfunction

    function automatic logic signed [SUM_W-1:0] widen(input logic signed [P_W-1:0] v);
        widen = {{(SUM_W-P_W){v[P_W-1]}}, v};
    endfunction

    // Register storage
    logic [WORD_W-1:0] slot_q [NUM_SLOTS];

    // Control port state
    port_state_t       state_reg;
    port_state_t       state_next;
    logic [SUB_W-1:0]  sub_reg;
    logic [1:0]        byte_cnt_reg;
    logic [23:0]       acc_reg;
    logic [WORD_W-1:0] rd_snap_reg;
    logic [1:0]        rd_cnt_reg;

    // Port decode
    logic              active;
    logic              wr_take;
    logic              word_done;
    logic              rd_take;
    logic [WORD_W-1:0] wr_word;
    logic [IDX_W:0]    wr_slot;
    logic [IDX_W:0]    rd_slot;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] rd_src;

    assign active    = (state_reg == PORT_ACTIVE);
    assign wr_take   = active && wr_valid && !sub_valid;
    assign word_done = wr_take && (byte_cnt_reg == LAST_BYTE); // RULE_21
    assign wr_word   = {acc_reg, wr_byte};
    assign wr_slot   = slot_of(sub_reg);
    assign rd_take   = active && rd_req && !sub_valid && !wr_valid;
    assign rd_slot   = slot_of(sub_reg);
    assign rd_word   = rd_slot[IDX_W] ? slot_q[rd_slot[IDX_W-1:0]] : RST_ZERO;
    // Whole word captured on its first byte so a read never tears
    assign rd_src    = (rd_cnt_reg == 2'd0) ? rd_word : rd_snap_reg;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PORT_IDLE:
            begin
                if (sub_valid)
                    state_next = PORT_ACTIVE;
            end
            PORT_ACTIVE:
            begin
                if (stop && !sub_valid)
                    state_next = PORT_IDLE;
            end
            default: state_next = PORT_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            state_reg <= PORT_IDLE;
        else
            state_reg <= state_next;
    end

    // Address pointer and write byte assembly, MSB first
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sub_reg      <= 8'h00;
            byte_cnt_reg <= 2'd0;
            acc_reg      <= 24'h00_0000;
        end
        else if (sub_valid)
        begin
            sub_reg      <= sub_addr;
            byte_cnt_reg <= 2'd0;
        end
        else if (wr_take)
        begin
            acc_reg      <= {acc_reg[15:0], wr_byte};
            byte_cnt_reg <= byte_cnt_reg + 2'd1;
            if (word_done)
                sub_reg  <= sub_reg + 8'h01;
        end
        else if (rd_take && rd_cnt_reg == LAST_BYTE)
            sub_reg      <= sub_reg + 8'h01;
        else if (stop)
            byte_cnt_reg <= 2'd0;
    end

    // Registers change only on a full word
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NUM_SLOTS; i++)
                slot_q[i] <= slot_reset(IDX_W'(i));
        end
        else if (word_done && wr_slot[IDX_W])
            slot_q[wr_slot[IDX_W-1:0]] <=
                filter_write(wr_slot[IDX_W-1:0], slot_q[wr_slot[IDX_W-1:0]], wr_word); // RULE_21
    end

    // Read byte path
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rd_cnt_reg  <= 2'd0;
            rd_snap_reg <= RST_ZERO;
            rd_byte     <= 8'h00;
            rd_valid    <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_take;
            if (sub_valid || stop)
                rd_cnt_reg <= 2'd0;
            else if (rd_take)
            begin
                rd_cnt_reg  <= rd_cnt_reg + 2'd1;
                rd_snap_reg <= rd_src;
                rd_byte     <= rd_src[8*(3-rd_cnt_reg) +: 8];
            end
        end
    end

    // Tuned frequency decode
    logic [WORD_W-1:0]     tune_word;
    logic [3:0]            bcd_hund;
    logic [3:0]            bcd_tens;
    logic [3:0]            bcd_unit;
    logic                  bcd_thou;
    logic [BIN_FREQ_W-1:0] bcd_khz;
    logic [BIN_FREQ_W-1:0] bin_khz;
    logic                  bcd_bad_w;
    logic                  bin_sel;

    assign tune_word = slot_q[0];
    assign bin_sel   = tune_word[TUNE_BIN_SEL_BIT]; // RULE_04
    assign bcd_thou  = tune_word[BCD_THOU_BIT]; // RULE_01
    assign bcd_hund  = tune_word[BCD_HUND_LSB +: 4]; // RULE_01
    assign bcd_tens  = tune_word[BCD_TENS_LSB +: 4]; // RULE_02
    assign bcd_unit  = tune_word[BCD_UNIT_LSB +: 4]; // RULE_02
    // Digits widened first: a 7-bit product would wrap from 200 up
    assign bcd_khz   = (bcd_thou ? 11'd1000 : 11'd0)
                     + BIN_FREQ_W'(bcd_hund) * 11'd100
                     + BIN_FREQ_W'(bcd_tens) * 11'd10
                     + BIN_FREQ_W'(bcd_unit);
    assign bcd_bad_w = (bcd_hund > BCD_DIGIT_MAX) || (bcd_tens > BCD_DIGIT_MAX)
                     || (bcd_unit > BCD_DIGIT_MAX);
    assign bin_khz   = tune_word[BIN_FREQ_W-1:0]; // RULE_03

    // Supply-volume range decode
    logic [1:0]  range_w;
    logic [11:0] range_cdb_w;

    assign range_w     = slot_q[1][1:0];
    assign range_cdb_w = (range_w == RANGE_18DB) ? RANGE_18DB_CDB :
                         (range_w == RANGE_24DB) ? RANGE_24DB_CDB :
                                                   RANGE_12DB_CDB; // RULE_05

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            tuning         <= '0;
            range_code     <= RANGE_12DB;
            range_cdb      <= RANGE_12DB_CDB;
            lineout_six_ch <= 1'b0;
            svc_enable     <= 1'b0;
            sub_separate   <= 1'b0;
        end
        else
        begin
            tuning.binary_sel <= bin_sel;
            tuning.bcd_bad    <= !bin_sel && bcd_bad_w;
            tuning.freq_khz   <= bin_sel ? bin_khz : bcd_khz; // RULE_04
            range_code        <= range_w;
            range_cdb         <= range_cdb_w;
            lineout_six_ch    <= slot_q[2][GEN_LINEOUT_BIT]; // RULE_08
            svc_enable        <= slot_q[2][GEN_SVC_EN_BIT]; // RULE_09
            sub_separate      <= slot_q[2][GEN_SUB_SEP_BIT]; // RULE_10
        end
    end

    // Downmix terms: left sums on 0-3, right on 4-7
    logic signed [SAMPLE_W-1:0] term_smp  [8];
    logic signed [COEF_W-1:0]   term_coef [8];
    logic signed [P_W-1:0]      term_out  [8];
    logic signed [COEF_W-1:0]   c_in1;
    logic signed [COEF_W-1:0]   c_in4;

    assign c_in1        = slot_q[5][COEF_W-1:0];
    assign c_in4        = slot_q[6][COEF_W-1:0];
    assign term_smp[0]  = in1.left; // RULE_13
    assign term_coef[0] = c_in1;
    assign term_smp[1]  = in4.left; // RULE_13
    assign term_coef[1] = c_in4;
    assign term_smp[2]  = in2.left; // RULE_14
    assign term_coef[2] = slot_q[9][COEF_W-1:0];
    assign term_smp[3]  = in2.right; // RULE_14
    assign term_coef[3] = slot_q[10][COEF_W-1:0];
    assign term_smp[4]  = in1.right; // RULE_13
    assign term_coef[4] = c_in1;
    assign term_smp[5]  = in4.left; // RULE_13
    assign term_coef[5] = c_in4;
    assign term_smp[6]  = in2.left; // RULE_14
    assign term_coef[6] = slot_q[7][COEF_W-1:0];
    assign term_smp[7]  = in2.right; // RULE_14
    assign term_coef[7] = slot_q[8][COEF_W-1:0];

    for (genvar t = 0; t < 8; t++)
    begin : g_term
        gain_scale u_term (
            .sample (term_smp[t]),
            .coef   (term_coef[t]),
            .scaled (term_out[t])
        );
    end

    logic signed [SUM_W-1:0] sum_l;
    logic signed [SUM_W-1:0] sum_r;

    assign sum_l = widen(term_out[0]) + widen(term_out[1])
                 + widen(term_out[2]) + widen(term_out[3]);
    assign sum_r = widen(term_out[4]) + widen(term_out[5])
                 + widen(term_out[6]) + widen(term_out[7]);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mix_valid <= 1'b0;
            mix_out   <= '0;
        end
        else
        begin
            mix_valid <= smp_valid;
            if (smp_valid)
            begin
                mix_out.left  <= saturate(sum_l);
                mix_out.right <= saturate(sum_r);
            end
        end
    end

    // Clip manager: boost into clip, then cut
    logic signed [P_W-1:0]      pre_out;
    logic signed [P_W-1:0]      post_out;
    logic signed [SAMPLE_W-1:0] clipped_reg;
    logic                       clipped_vld_reg;

    gain_scale u_pre (
        .sample (clip_in),
        .coef   (slot_q[11][COEF_W-1:0]), // RULE_19
        .scaled (pre_out)
    );

    gain_scale u_post (
        .sample (clipped_reg),
        .coef   (slot_q[12][COEF_W-1:0]), // RULE_18
        .scaled (post_out)
    );

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            clipped_reg     <= '0;
            clipped_vld_reg <= 1'b0;
            clip_out        <= '0;
            clip_out_valid  <= 1'b0;
        end
        else
        begin
            clipped_vld_reg <= clip_in_valid;
            clip_out_valid  <= clipped_vld_reg;
            if (clip_in_valid)
                clipped_reg <= saturate(widen(pre_out)); // RULE_16
            if (clipped_vld_reg)
                clip_out    <= saturate(widen(post_out)); // RULE_16
        end
    end

endmodule
`default_nettype wire

// >>> design/audio_tuning_pkg.sv
// Constants, reset values and carrier types of the register bank
package audio_tuning_pkg;

    // Serial control port geometry
    localparam int SUB_W      = 8;
    localparam int BYTE_W     = 8;
    localparam int WORD_W     = 32;
    localparam int WORD_BYTES = 4;
    localparam int COEF_W     = 28;
    localparam int FRAC_BITS  = 23;
    localparam int SAMPLE_W   = 24;

    // Subaddresses
    localparam logic [7:0] SUB_TUNED    = 8'hDE;
    localparam logic [7:0] SUB_RANGE    = 8'hDF;
    localparam logic [7:0] SUB_GENERAL  = 8'hE0;
    localparam logic [7:0] SUB_MIX_IN1  = 8'hE3;
    localparam logic [7:0] SUB_MIX_IN4  = 8'hE4;
    localparam logic [7:0] SUB_IN2L_OR  = 8'hE5;
    localparam logic [7:0] SUB_IN2R_OR  = 8'hE6;
    localparam logic [7:0] SUB_IN2L_OL  = 8'hE7;
    localparam logic [7:0] SUB_IN2R_OL  = 8'hE8;
    localparam logic [7:0] SUB_PRE      = 8'hE9;
    localparam logic [7:0] SUB_POST     = 8'hEA;
    localparam int         NUM_SLOTS    = 13;

    // Tuned frequency and AM mode fields
    localparam int TUNE_BIN_SEL_BIT = 16;
    localparam int BCD_THOU_BIT     = 12;
    localparam int BCD_HUND_LSB     = 8;
    localparam int BCD_TENS_LSB     = 4;
    localparam int BCD_UNIT_LSB     = 0;
    localparam int BIN_FREQ_W       = 11;
    localparam logic [31:0] TUNE_KEEP_MASK = 32'h0001_1FFF;
    localparam logic [3:0]  BCD_DIGIT_MAX  = 4'h9;

    // Supply-volume range field
    localparam logic [31:0] RANGE_MASK     = 32'h0000_0003;
    localparam logic [1:0]  RANGE_IGNORE   = 2'h3;
    localparam logic [1:0]  RANGE_12DB     = 2'h0;
    localparam logic [1:0]  RANGE_18DB     = 2'h1;
    localparam logic [1:0]  RANGE_24DB     = 2'h2;
    localparam logic [11:0] RANGE_12DB_CDB = 12'h4_B4;
    localparam logic [11:0] RANGE_18DB_CDB = 12'h7_0E;
    localparam logic [11:0] RANGE_24DB_CDB = 12'h9_68;

    // General control fields
    localparam int GEN_LINEOUT_BIT = 1;
    localparam int GEN_SVC_EN_BIT  = 2;
    localparam int GEN_SUB_SEP_BIT = 3;
    localparam logic [31:0] GEN_MASK  = 32'h0000_000E;
    localparam logic [31:0] COEF_MASK = 32'h0FFF_FFFF;

    // Reset values
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic [31:0] RST_MIX_IN1 = 32'h0029_0333;
    localparam logic [31:0] RST_MIX_IN4 = 32'h001C_FEEF;
    localparam logic [31:0] RST_MIX_IN2 = 32'hFFE3_0111;
    localparam logic [31:0] RST_UNITY   = 32'h0080_0000;

    typedef enum logic [0:0] {
        PORT_IDLE   = 1'b0,
        PORT_ACTIVE = 1'b1
    } port_state_t;

    typedef struct packed {
        logic                  binary_sel;
        logic                  bcd_bad;
        logic [BIN_FREQ_W-1:0] freq_khz;
    } tuning_t;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] left;
        logic signed [SAMPLE_W-1:0] right;
    } stereo_t;

endpackage

// >>> design/gain_scale.sv
// Signed sample times 5.23 gain coefficient, rescaled to sample units
`timescale 1ns/1ns
`default_nettype none
module gain_scale
    import audio_tuning_pkg::*;
#(
    parameter int SW = SAMPLE_W,
    parameter int CW = COEF_W,
    parameter int FB = FRAC_BITS
)
(
    // Operands
    input  wire logic signed [SW-1:0]      sample,
    input  wire logic signed [CW-1:0]      coef,
    // Product with fractional bits dropped
    output logic signed      [SW+CW-FB-1:0] scaled
);

    logic signed [SW+CW-1:0] product;

    assign product = sample * coef;
    // Floor; rounding costs an adder per term
    assign scaled  = product[SW+CW-1:FB];

endmodule
`default_nettype wire

// >>> tb/ctrl_host.sv
// Byte-level host model driving the serial control port
`timescale 1ns/1ns
`default_nettype none
module ctrl_host
    import audio_tuning_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Requests to the device
    output logic                   sub_valid,
    output logic [SUB_W-1:0]       sub_addr,
    output logic                   wr_valid,
    output logic [BYTE_W-1:0]      wr_byte,
    output logic                   rd_req,
    output logic                   stop,
    // Answers
    input  wire logic [BYTE_W-1:0] rd_byte,
    input  wire logic              rd_valid
);
    logic [WORD_W-1:0] rword;

    initial {sub_valid, sub_addr, wr_valid, wr_byte, rd_req, stop} = '0;

    always @(posedge clk)
        if (rd_valid)
            rword <= {rword[23:0], rd_byte};

    // Short count leaves a partial word for stop
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
        @(posedge clk);
        #2 sub_valid = 1'b1;
        sub_addr = a;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            #2 sub_valid = 1'b0;
            wr_valid = 1'b1;
            wr_byte = d[31-8*i -: 8];
        end
        @(posedge clk);
        #2 {sub_valid, wr_valid, stop} = 3'h1;
        wr_byte = ~wr_byte;
        @(posedge clk);
        #2 stop = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        #2 sub_valid = 1'b1;
        sub_addr = a;
        repeat (4)
        begin
            @(posedge clk);
            #2 sub_valid = 1'b0;
            rd_req = 1'b1;
        end
        @(posedge clk);
        #2 rd_req = 1'b0;
        @(posedge clk);
        #2 stop = 1'b1;
        @(posedge clk);
        #2 stop = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/regs_checker_assertions.sv
// Port-level assertions for the register bank
`timescale 1ns/1ns
`default_nettype none
module regs_checker
    import audio_tuning_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register port
    input wire logic        wr_valid,
    // Settings
    input wire tuning_t     tuning,
    input wire logic [1:0]  range_code,
    input wire logic [11:0] range_cdb,
    input wire logic        lineout_six_ch,
    input wire logic        svc_enable,
    input wire logic        sub_separate,
    // Datapaths
    input wire logic        smp_valid,
    input wire logic        mix_valid,
    input wire stereo_t     mix_out,
    input wire logic        clip_in_valid,
    input wire logic        clip_out_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    wire logic [11:0] cdb_exp = (range_code == RANGE_24DB) ? RANGE_24DB_CDB :
                                (range_code == RANGE_18DB) ? RANGE_18DB_CDB : RANGE_12DB_CDB;
    wire logic [4:0]  setting = {range_code, lineout_six_ch, svc_enable, sub_separate};

    property p_range_legal; range_code != RANGE_IGNORE; endproperty
    a_range_legal: assert property (p_range_legal) else $error("range code 11 stored");
    property p_range_cdb; range_code == $past(range_code) |-> range_cdb == cdb_exp; endproperty
    a_range_cdb: assert property (p_range_cdb) else $error("range in dB wrong");
    // Settings move only two edges after a taken byte
    property p_set_cause; $changed(setting) |-> $past(wr_valid, 2); endproperty
    a_set_cause: assert property (p_set_cause) else $error("setting moved");
    property p_bin_clean; tuning.binary_sel |-> !tuning.bcd_bad; endproperty
    a_bin_clean: assert property (p_bin_clean) else $error("digit flag in binary");
    property p_bcd_max;
        !tuning.binary_sel && !tuning.bcd_bad |-> tuning.freq_khz <= 11'h7CF;
    endproperty
    a_bcd_max: assert property (p_bcd_max) else $error("tuning too large");
    property p_mix_lat; smp_valid |=> mix_valid; endproperty
    a_mix_lat: assert property (p_mix_lat) else $error("downmix result missing");
    property p_mix_only; mix_valid |-> $past(smp_valid); endproperty
    a_mix_only: assert property (p_mix_only) else $error("downmix without sample");
    property p_mix_hold; !mix_valid |-> $stable(mix_out); endproperty
    a_mix_hold: assert property (p_mix_hold) else $error("downmix output moved");
    property p_clip_lat; clip_in_valid |=> ##1 clip_out_valid; endproperty
    a_clip_lat: assert property (p_clip_lat) else $error("clip result missing");
    property p_clip_only; clip_out_valid |-> $past(clip_in_valid, 2); endproperty
    a_clip_only: assert property (p_clip_only) else $error("clip without sample");
endmodule
bind audio_tuning_supply_mix_regs regs_checker u_chk (.*);
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import audio_tuning_pkg::*;
;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               sub_valid, wr_valid, rd_req, stop, rd_valid;
    logic [7:0]         sub_addr, wr_byte, rd_byte;
    logic               smp_valid = 1'b0, clip_in_valid = 1'b0, mix_valid, clip_out_valid;
    logic signed [23:0] clip_in = '0, clip_out;
    stereo_t            in1 = '0, in2 = '0, in4 = '0, mix_out;
    tuning_t            tuning;
    logic [1:0]         range_code;
    logic [11:0]        range_cdb;
    logic               lineout_six_ch, svc_enable, sub_separate;
    logic [31:0]        sh [13];
    int                 n_mismatch = 0, checks_done = 0, cyc = 0, i, k;

    always #10 clk = ~clk;

    audio_tuning_supply_mix_regs DUT (.*);
    ctrl_host host (.*);

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [31:0] stored(input logic [7:0] a, input logic [31:0] v, o);
        case (a)
            SUB_TUNED:          return v & TUNE_KEEP_MASK;
            SUB_RANGE:          return (v[1:0] == RANGE_IGNORE) ? o : v & RANGE_MASK;
            SUB_GENERAL:        return v & GEN_MASK;
            SUB_PRE, SUB_POST:  return v & COEF_MASK;
            8'hE1, 8'hE2:       return RST_ZERO;
            default:            return {{4{v[27]}}, v[27:0]};
        endcase
    endfunction

    function automatic logic signed [63:0] mul(input logic signed [23:0] s, logic [31:0] c);
        logic signed [63:0] a, b;
        a = s;
        b = $signed(c[27:0]);
        return (a * b) >>> 23;
    endfunction

    function automatic logic signed [23:0] sat(input logic signed [63:0] x);
        if (x > 8388607)
            return 24'h7F_FFFF;
        if (x < -8388608)
            return 24'h80_0000;
        return x[23:0];
    endfunction

    function automatic logic [11:0] cdb(input logic [1:0] c);
        return (c == 2'h2) ? RANGE_24DB_CDB : (c == 2'h1) ? RANGE_18DB_CDB : RANGE_12DB_CDB;
    endfunction

    task automatic sh_init();
        sh = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_MIX_IN1, RST_MIX_IN4,
               RST_MIX_IN2, RST_MIX_IN2, RST_MIX_IN2, RST_MIX_IN2, RST_UNITY, RST_UNITY};
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d, 4);
        sh[a - 8'hDE] = stored(a, d, sh[a - 8'hDE]);
    endtask

    task automatic clip(input logic signed [23:0] x);
        @(posedge clk);
        #2 clip_in = x;
        clip_in_valid = 1'b1;
        @(posedge clk);
        #2 clip_in_valid = 1'b0;
        clip_in = ~x;
        @(posedge clk);
        #2 chk(clip_out_valid, 1'b1);
        chk(clip_out, sat(mul(sat(mul(x, sh[11])), sh[12])));
    endtask

    task automatic mix();
        logic signed [63:0] l, r;
        @(posedge clk);
        #2 in1 = {24'($urandom), 24'($urandom)};
        in2 = {24'($urandom), 24'($urandom)};
        in4 = {24'($urandom), 24'($urandom)};
        smp_valid = 1'b1;
        l = mul(in1.left, sh[5]) + mul(in4.left, sh[6]) + mul(in2.left, sh[9])
            + mul(in2.right, sh[10]);
        r = mul(in1.right, sh[5]) + mul(in4.left, sh[6]) + mul(in2.left, sh[7])
            + mul(in2.right, sh[8]);
        @(posedge clk);
        #2 smp_valid = 1'b0;
        chk(mix_valid, 1'b1);
        chk(mix_out, {sat(l), sat(r)});
    endtask

    // Run needs about 1800 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            results();
        end
    end

    initial
    begin
        sh_init();
        repeat (4) @(posedge clk);
        #2 rstn = 1'b1;
        void'($urandom(32'he8a3_229d));
        for (i = 0; i < 14; i++)
        begin
            host.rd(8'hDE + i[7:0]);
            chk(host.rword, (i < 13) ? sh[i] : RST_ZERO);
        end
        put(SUB_TUNED, 32'h0000_1987);
        chk(tuning, {2'h0, 11'h7C3});
        put(SUB_TUNED, 32'h0001_07FF);
        chk(tuning, {2'h2, 11'h7FF});
        put(SUB_TUNED, 32'h0000_00A0);
        chk(tuning[12:11], 2'h1);
        // Code 11 arrives after 10 and must leave 24 dB in place
        for (i = 1; i < 5; i++)
        begin
            put(SUB_RANGE, {30'h0, i[1:0]});
            k = (i == 3) ? 2 : i % 4;
            chk(range_code, k[1:0]);
            chk(range_cdb, cdb(k[1:0]));
        end
        for (i = 0; i < 8; i++)
        begin
            put(SUB_GENERAL, {28'h0, i[2:0], 1'b0});
            chk({sub_separate, svc_enable, lineout_six_ch}, i[2:0]);
        end
        for (i = 0; i < 60; i++)
        begin
            k = $urandom_range(12);
            put(8'hDE + k[7:0], $urandom);
            host.rd(8'hDE + k[7:0]);
            chk(host.rword, sh[k]);
        end
        host.wr(SUB_PRE, 32'h1234_5678, 3);
        host.rd(SUB_PRE);
        chk(host.rword, sh[11]);
        for (i = 0; i < 12; i++)
        begin
            put(SUB_PRE, (i == 0) ? 32'h07FF_FFFF : (i == 1) ? RST_UNITY : $urandom);
            put(SUB_POST, (i < 2) ? 32'h0F80_0000 : $urandom);
            repeat (4) clip(24'($urandom));
        end
        for (i = 0; i < 8; i++)
        begin
            for (k = 5; k < 11 && i > 0; k++)
                put(8'hDE + k[7:0], $urandom);
            repeat (3) mix();
        end
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #2 rstn = 1'b1;
        sh_init();
        host.rd(SUB_POST);
        chk(host.rword, RST_UNITY);
        results();
    end
endmodule
`default_nettype wire
